// ---- rtl/rsc_rx_flags.sv ----
//////////////////////////////////////////////////////////////////////////////
// Receive statistic counters, their control register and the receive
// interrupt status register, reached over APB.
// Assumes event pulses and the APB master run on SYS_CLK_I.
//////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the APB slave port.
module rsc_rx_flags
  import rsc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire rsc_apb_req_t APB_REQ_I,
  output rsc_apb_rsp_t APB_RSP_O,
  input wire logic [23:0] EVT_I,
  input wire logic [15:0] OCTET_LEN_I
);

  localparam logic [31:0] HALF_VAL = 32'h8000_0000;
  localparam logic [31:0] MAX_VAL = 32'hFFFF_FFFF;
  localparam logic [23:0] OCTET_MASK =
    (24'h000001 << RSC_RX_TOTAL_BYTE_COUNT) |
    (24'h000001 << RSC_RX_GOOD_BYTE_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.
  ////////////////////////////////////////////////////////////////////////////

  // Returns a hit bit above the counter index for a counter address.
  function automatic logic [5:0] cnt_decode(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - RSC_OFS_CNT_BASE;
    cnt_decode = 6'h00;
    if (addr >= RSC_OFS_CNT_BASE && rel[1:0] == 2'h0 &&
        rel[11:2] < 10'(RSC_NUM_CNT)) begin
      cnt_decode = {1'b1, rel[6:2]};
    end
  endfunction

  // Preset value: the half or full point less the counter's gap.
  function automatic logic [31:0] preset_val(input logic octet,
                                             input logic full);
    logic [32:0] base;
    logic [32:0] gap;
    base = full ? 33'h1_0000_0000 : {1'b0, HALF_VAL};
    gap = {1'b0, octet ? RSC_OCT_PRE_GAP : RSC_FRM_PRE_GAP};
    preset_val = 32'(base - gap);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and next-state logic.
  ////////////////////////////////////////////////////////////////////////////

  rsc_state_t s_q;
  rsc_state_t s_d;

  logic acc_rd;
  logic acc_wr;
  logic setup_rd;
  logic [5:0] acc_sel;
  logic [5:0] setup_sel;
  logic acc_mapped;
  logic [23:0] rd_clr_v;
  logic [23:0] upd_v;
  logic [23:0] set_v;
  logic [23:0][31:0] base_v;

  assign acc_rd = APB_REQ_I.psel && APB_REQ_I.penable && !APB_REQ_I.pwrite;
  assign acc_wr = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite;
  assign setup_rd = APB_REQ_I.psel && !APB_REQ_I.penable &&
                    !APB_REQ_I.pwrite;
  assign acc_sel = cnt_decode(APB_REQ_I.paddr);
  assign setup_sel = acc_sel;
  assign acc_mapped = acc_sel[5] ||
                      APB_REQ_I.paddr == RSC_OFS_CTRL ||
                      APB_REQ_I.paddr == RSC_OFS_IRQ_STAT;

  always_comb begin
    logic [32:0] sum;
    logic [31:0] inc;
    logic [31:0] nv;
    logic wrap;
    logic stop;
    logic [23:0] nf;
    sum = 33'h0_0000_0000;
    nf = 24'h000000;
    inc = 32'h0000_0000;
    nv = 32'h0000_0000;
    wrap = 1'b0;
    stop = s_q.ctl[RSC_CTL_STOP_ROLL];
    s_d = s_q;
    rd_clr_v = 24'h000000;
    upd_v = 24'h000000;
    set_v = 24'h000000;
    base_v = s_q.cnt;

    // Reset and preset commands act for exactly one cycle.
    s_d.ctl[RSC_CTL_RESET] = 1'b0;
    s_d.ctl[RSC_CTL_PRESET] = 1'b0;
    if (acc_wr && APB_REQ_I.paddr == RSC_OFS_CTRL) begin
      s_d.ctl = APB_REQ_I.pwdata[RSC_CTL_W-1:0];
    end

    // APB reads always carry all four byte lanes, so any counter read
    // includes bits 7:0 and therefore clears.
    if (acc_rd && acc_sel[5]) begin
      rd_clr_v[acc_sel[4:0]] = 1'b1;
    end

    for (int i = 0; i < RSC_NUM_CNT; i++) begin
      if (s_q.ctl[RSC_CTL_RESET]) begin
        base_v[i] = 32'h0000_0000;
      end else if (s_q.ctl[RSC_CTL_PRESET]) begin
        base_v[i] = preset_val(OCTET_MASK[i],
                               s_q.ctl[RSC_CTL_FULL_HALF]);
      end else if (rd_clr_v[i] && s_q.ctl[RSC_CTL_RD_CLR]) begin
        base_v[i] = 32'h0000_0000;
      end
      inc = OCTET_MASK[i] ? {16'h0000, OCTET_LEN_I} : 32'h0000_0001;
      upd_v[i] = EVT_I[i] && !s_q.ctl[RSC_CTL_FREEZE];
      sum = {1'b0, base_v[i]} + {1'b0, inc};
      wrap = sum[32];
      if (wrap && stop) begin
        nv = MAX_VAL;
      end else begin
        nv = sum[31:0];
      end
      // Octet counters move in steps, so crossing a threshold counts.
      set_v[i] = upd_v[i] && ((!base_v[i][31] && nv[31]) ||
                 (nv == MAX_VAL && base_v[i] != MAX_VAL) ||
                 (wrap && !stop));
      s_d.cnt[i] = upd_v[i] ? nv : base_v[i];
    end

    // A status read leaves the flags alone. Flag i belongs to counter i,
    // so each group of bits is owned by the counters listed in the enum.
    nf = (s_q.flags & ~rd_clr_v) | set_v;
    s_d.flags[23] = nf[23];
    s_d.flags[22] = nf[22];
    s_d.flags[21] = nf[21];
    s_d.flags[20] = nf[20];
    s_d.flags[19] = nf[19];
    s_d.flags[18] = nf[18];
    s_d.flags[17] = nf[17];
    s_d.flags[16:11] = nf[16:11];
    s_d.flags[10:9] = nf[10:9];
    s_d.flags[8:7] = nf[8:7];
    s_d.flags[6:5] = nf[6:5];
    s_d.flags[4:3] = nf[4:3];
    s_d.flags[2:1] = nf[2:1];
    s_d.flags[0] = nf[0];

    // Read data is captured in the setup phase so it leaves a flop.
    if (setup_rd) begin
      if (setup_sel[5]) begin
        s_d.prdata = s_q.cnt[setup_sel[4:0]];
      end else if (APB_REQ_I.paddr == RSC_OFS_CTRL) begin
        s_d.prdata = {26'h000_0000, s_q.ctl};
      end else if (APB_REQ_I.paddr == RSC_OFS_IRQ_STAT) begin
        s_d.prdata = {8'h00, s_q.flags};
      end else begin
        s_d.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q.flags <= RSC_FLAG_RST_VAL;
      s_q.ctl <= RSC_CTL_RST_VAL;
      s_q.cnt <= '0;
      s_q.prdata <= 32'h0000_0000;
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer.
  ////////////////////////////////////////////////////////////////////////////

  // Stalling pready while the enable is low keeps the master from
  // completing a transfer whose side effects would be frozen away.
  assign APB_RSP_O.pready = CE_I;
  assign APB_RSP_O.pslverr = CE_I && APB_REQ_I.psel &&
                             APB_REQ_I.penable && !acc_mapped;
  assign APB_RSP_O.prdata = s_q.prdata;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);

  logic plain_cycle;
  assign plain_cycle = !s_q.ctl[RSC_CTL_RESET] && !s_q.ctl[RSC_CTL_PRESET];

  a_half_sets_flag: assert property (
    CE_I && plain_cycle && upd_v[0] && !rd_clr_v[0] &&
    s_q.cnt[0] == HALF_VAL - 32'h0000_0001
    |=> s_q.flags[0] && s_q.cnt[0] == HALF_VAL)
    else $error("half threshold did not set flag 0");

  a_max_sets_flag: assert property (
    CE_I && upd_v[5] && base_v[5] == MAX_VAL - 32'h0000_0001
    |=> s_q.flags[5] && s_q.cnt[5] == MAX_VAL)
    else $error("max threshold did not set flag 5");

  a_stop_holds_max: assert property (
    CE_I && s_q.ctl[RSC_CTL_STOP_ROLL] && upd_v[3] &&
    base_v[3] == MAX_VAL
    |=> s_q.cnt[3] == MAX_VAL)
    else $error("saturated counter 3 moved");

  a_octet_no_wrap: assert property (
    CE_I && s_q.ctl[RSC_CTL_STOP_ROLL] && upd_v[1] && OCTET_LEN_I != 0 &&
    base_v[1] != MAX_VAL &&
    base_v[1] > MAX_VAL - {16'h0000, OCTET_LEN_I}
    |=> s_q.cnt[1] == MAX_VAL && s_q.flags[1])
    else $error("octet counter wrapped under stop rollover");

  a_stat_read_keeps: assert property (
    CE_I && acc_rd && APB_REQ_I.paddr == RSC_OFS_IRQ_STAT
    |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
    else $error("status read cleared a flag");

  a_cnt_read_clears: assert property (
    CE_I && acc_rd && acc_sel == 6'h27 && !set_v[7]
    |=> !s_q.flags[7])
    else $error("counter read did not clear flag 7");

  a_set_beats_clear: assert property (
    CE_I && rd_clr_v[9] && set_v[9]
    |=> s_q.flags[9])
    else $error("same-cycle read lost flag 9 event");

  a_reserved_reads_zero: assert property (
    APB_REQ_I.psel && APB_REQ_I.penable && !APB_REQ_I.pwrite &&
    APB_REQ_I.paddr == RSC_OFS_IRQ_STAT
    |-> APB_RSP_O.prdata[31:24] == 8'h00)
    else $error("reserved status bits not zero");

  a_preset_half_val: assert property (
    CE_I && s_q.ctl[RSC_CTL_PRESET] && !s_q.ctl[RSC_CTL_RESET] &&
    !s_q.ctl[RSC_CTL_FULL_HALF] && !upd_v[2] && !upd_v[0]
    |=> s_q.cnt[2] == HALF_VAL - RSC_OCT_PRE_GAP &&
        s_q.cnt[0] == HALF_VAL - RSC_FRM_PRE_GAP)
    else $error("half preset loaded wrong values");

  a_preset_one_cycle: assert property (
    CE_I && s_q.ctl[RSC_CTL_PRESET] && !acc_wr
    |=> !s_q.ctl[RSC_CTL_PRESET])
    else $error("preset bit did not self clear");

  a_flags_need_cause: assert property (
    CE_I && !set_v[23] |=> !s_q.flags[23] || $past(s_q.flags[23]))
    else $error("flag 23 rose without a threshold event");

  a_half_flag_top: assert property (
    CE_I && upd_v[23] && base_v[23] == HALF_VAL - 32'h0000_0001
    |=> s_q.flags[23])
    else $error("half threshold did not set flag 23");

  a_half_flag_tag: assert property (
    CE_I && upd_v[22] && base_v[22] == HALF_VAL - 32'h0000_0001
    |=> s_q.flags[22])
    else $error("half threshold did not set flag 22");

  a_half_flag_bucket: assert property (
    CE_I && upd_v[11] && base_v[11] == HALF_VAL - 32'h0000_0001
    |=> s_q.flags[11])
    else $error("half threshold did not set flag 11");

  a_wrap_sets_flag: assert property (
    CE_I && !s_q.ctl[RSC_CTL_STOP_ROLL] && upd_v[2] &&
    base_v[2] > MAX_VAL - {16'h0000, OCTET_LEN_I}
    |=> s_q.flags[2])
    else $error("octet wrap did not set flag 2");

  a_held_no_flag: assert property (
    CE_I && s_q.ctl[RSC_CTL_STOP_ROLL] && upd_v[12] &&
    base_v[12] == MAX_VAL && !s_q.flags[12]
    |=> !s_q.flags[12] && s_q.cnt[12] == MAX_VAL)
    else $error("held counter 12 raised a flag");

  a_stat_read_data: assert property (
    CE_I && setup_rd && APB_REQ_I.paddr == RSC_OFS_IRQ_STAT
    |=> APB_RSP_O.prdata == {8'h00, $past(s_q.flags)})
    else $error("status read data does not match the flags");

  a_cnt_read_data: assert property (
    CE_I && setup_rd && setup_sel[5]
    |=> APB_RSP_O.prdata == $past(s_q.cnt[setup_sel[4:0]]))
    else $error("counter read data does not match the counter");

  a_read_zeroes_cnt: assert property (
    CE_I && plain_cycle && acc_rd && acc_sel == 6'h23 &&
    s_q.ctl[RSC_CTL_RD_CLR] && !upd_v[3]
    |=> s_q.cnt[3] == 32'h0000_0000)
    else $error("reset on read left counter 3 nonzero");

  a_reset_cmd_zero: assert property (
    CE_I && s_q.ctl[RSC_CTL_RESET] && !upd_v[6]
    |=> s_q.cnt[6] == 32'h0000_0000)
    else $error("reset command left counter 6 nonzero");

  // An unmapped access must be refused so that software sees its error
  // instead of silently reading zero.
  a_unmapped_err: assert property (
    CE_I && APB_REQ_I.psel && APB_REQ_I.penable && !acc_mapped
    |-> APB_RSP_O.pslverr)
    else $error("unmapped access gave no error");

  c_half_flag: cover property (
    CE_I && set_v[0] ##1 s_q.flags[0]);

  c_stop_hold: cover property (
    CE_I && s_q.ctl[RSC_CTL_STOP_ROLL] && upd_v[3] &&
    base_v[3] == MAX_VAL);

  c_set_and_clear: cover property (
    CE_I && |(rd_clr_v & set_v));

  c_preset_full: cover property (
    CE_I && s_q.ctl[RSC_CTL_PRESET] && s_q.ctl[RSC_CTL_FULL_HALF]);

endmodule

// ---- shared/rsc_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Package for the receive statistic counter and interrupt flag bank.
// Assumes one register clock and an APB master on the same clock.
//////////////////////////////////////////////////////////////////////////////
package rsc_pkg;

  localparam int RSC_NUM_CNT = 24;
  localparam int RSC_CNT_W = 32;
  localparam int RSC_AW = 12;
  localparam int RSC_LEN_W = 16;

  // Register byte offsets.
  localparam logic [11:0] RSC_OFS_CTRL = 12'h100;
  localparam logic [11:0] RSC_OFS_IRQ_STAT = 12'h104;
  localparam logic [11:0] RSC_OFS_CNT_BASE = 12'h180;

  // Control register field positions, width and reset value.
  localparam int RSC_CTL_RESET = 0;
  localparam int RSC_CTL_STOP_ROLL = 1;
  localparam int RSC_CTL_RD_CLR = 2;
  localparam int RSC_CTL_FREEZE = 3;
  localparam int RSC_CTL_PRESET = 4;
  localparam int RSC_CTL_FULL_HALF = 5;
  localparam int RSC_CTL_W = 6;
  localparam logic [5:0] RSC_CTL_RST_VAL = 6'h00;
  localparam logic [23:0] RSC_FLAG_RST_VAL = 24'h000000;

  // Distance below the half or full point that a preset lands on.
  localparam logic [31:0] RSC_OCT_PRE_GAP = 32'h0000_0800;
  localparam logic [31:0] RSC_FRM_PRE_GAP = 32'h0000_0010;

  // Counter index equals its flag bit in the interrupt status register.
  typedef enum logic [4:0] {
    RSC_RX_TOTAL_FRAME_COUNT = 5'h00,
    RSC_RX_TOTAL_BYTE_COUNT = 5'h01,
    RSC_RX_GOOD_BYTE_COUNT = 5'h02,
    RSC_RX_GOOD_BCAST_COUNT = 5'h03,
    RSC_RX_GOOD_MCAST_COUNT = 5'h04,
    RSC_RX_CRC_ERR_COUNT = 5'h05,
    RSC_RX_ALIGN_ERR_COUNT = 5'h06,
    RSC_RX_RUNT_ERR_COUNT = 5'h07,
    RSC_RX_JABBER_ERR_COUNT = 5'h08,
    RSC_RX_UNDERSIZE_COUNT = 5'h09,
    RSC_RX_OVERSIZE_COUNT = 5'h0A,
    RSC_RX_SIZE_BUCKET_MIN_COUNT = 5'h0B,
    RSC_RX_SIZE_BUCKET_65_COUNT = 5'h0C,
    RSC_RX_SIZE_BUCKET_128_COUNT = 5'h0D,
    RSC_RX_SIZE_BUCKET_256_COUNT = 5'h0E,
    RSC_RX_SIZE_BUCKET_512_COUNT = 5'h0F,
    RSC_RX_SIZE_BUCKET_LARGE_COUNT = 5'h10,
    RSC_RX_SINGLE_DEST_COUNT = 5'h11,
    RSC_RX_LEN_ERR_COUNT = 5'h12,
    RSC_RX_OUT_OF_RANGE_COUNT = 5'h13,
    RSC_RX_PAUSE_COUNT = 5'h14,
    RSC_RX_BUFFER_OVERRUN_COUNT = 5'h15,
    RSC_RX_TAGGED_FRAME_COUNT = 5'h16,
    RSC_RX_WATCHDOG_ERR_COUNT = 5'h17
  } rsc_cnt_e_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rsc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rsc_apb_rsp_t;

  typedef struct packed {
    logic [23:0] flags;
    logic [5:0] ctl;
    logic [23:0][31:0] cnt;
    logic [31:0] prdata;
  } rsc_state_t;

endpackage

// ---- test/rsc_apb_master.sv ----
//////////////////////////////////////////////////////////////////////////////
// APB master model standing in for software on the far side of the bank.
// Assumes the testbench calls xfer just after a rising edge of clk_i.
//////////////////////////////////////////////////////////////////////////////
module rsc_apb_master
  import rsc_pkg::*;
(
  input wire logic clk_i,
  output rsc_apb_req_t req_o,
  input wire rsc_apb_rsp_t rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_o = '0;
  end

  // One edge is left idle first, so a release is never overwritten at once.
  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic err);
    @(posedge clk_i);
    req_o.psel <= 1'b1;
    req_o.penable <= 1'b0;
    req_o.pwrite <= wr;
    req_o.paddr <= addr;
    req_o.pwdata <= wdata;
    @(posedge clk_i);
    req_o.penable <= 1'b1;
    do @(posedge clk_i); while (rsp_i.pready !== 1'b1);
    rdata = rsp_i.prdata;
    err = rsp_i.pslverr;
    req_o.psel <= 1'b0;
    req_o.penable <= 1'b0;
    // Released address and data lines show no stale value, so a late sample is caught.
    req_o.paddr <= ~addr;
    req_o.pwdata <= ~wdata;
  endtask
endmodule

// ---- test/rsc_rx_flags_test.sv ----
//////////////////////////////////////////////////////////////////////////////
// Self-checking testbench of the receive interrupt flag bank.
// Assumes zero-wait APB answers while CE_I is high.
//////////////////////////////////////////////////////////////////////////////
module rsc_rx_flags_test
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [23:0] evt = 24'h000000;
  logic [15:0] olen = 16'h0000;
  rsc_apb_req_t req;
  rsc_apb_rsp_t rsp;
  int seed = 99367;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  logic [23:0] mask;

  initial begin
    forever #12.5 clk = ~clk;
  end

  rsc_apb_master mst (.clk_i(clk), .req_o(req), .rsp_i(rsp));
  rsc_rx_flags dut (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce),
    .APB_REQ_I(req), .APB_RSP_O(rsp), .EVT_I(evt), .OCTET_LEN_I(olen));

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Octet counters take the byte amount, the others count events.
  function automatic logic [31:0] expect_cnt(input int i, input bit full,
                                             input logic [15:0] len,
                                             input int n);
    logic oct;
    oct = (i == 1 || i == 2);
    expect_cnt = (full ? 32'h0000_0000 : 32'h8000_0000)
      - (oct ? 32'h0000_0800 : 32'h0000_0010)
      + (oct ? {16'h0000, len} : 32'(n));
  endfunction

  task automatic rd_reg(input logic [11:0] a);
    mst.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    mst.xfer(1'b1, a, d, rd, err);
  endtask

  // Only the last event of a burst carries a byte amount.
  task automatic pulse(input logic [23:0] m, input int n,
                       input logic [15:0] len);
    for (int k = 1; k <= n; k++) begin
      @(posedge clk);
      evt <= m;
      olen <= (k == n) ? len : 16'h0000;
    end
    @(posedge clk);
    evt <= 24'h000000;
  endtask

  task automatic drain(input logic [23:0] m, input bit full,
                       input logic [15:0] len, input int n);
    logic [23:0] left;
    left = m;
    for (int i = 0; i < 24; i++) begin
      if (m[i]) begin
        rd_reg(RSC_OFS_CNT_BASE + 12'(4 * i));
        check(rd, expect_cnt(i, full, len, n));
        left[i] = 1'b0;
        rd_reg(RSC_OFS_IRQ_STAT);
        check(rd, {8'h00, left});
      end
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(RSC_OFS_IRQ_STAT);
    check(rd, 32'h0000_0000);
    wr_reg(RSC_OFS_IRQ_STAT, 32'hFFFF_FFFF);
    rd_reg(RSC_OFS_IRQ_STAT);
    check(rd, 32'h0000_0000);
    rd_reg(12'h0FC);
    check(32'(err), 32'h0000_0001);
    $display("test reset and access done");

    mask = 24'($random(seed)) | 24'h000001;
    wr_reg(RSC_OFS_CTRL, 32'h0000_0010);
    pulse(mask, 15, 16'h0000);
    rd_reg(RSC_OFS_IRQ_STAT);
    check(rd, 32'h0000_0000);
    pulse(mask, 1, 16'h0800);
    repeat (2) begin
      rd_reg(RSC_OFS_IRQ_STAT);
      check(32'(rd[23:17]), 32'(mask[23:17]));
      check(32'(rd[16:9]), 32'(mask[16:9]));
      check(32'(rd[8:0]), 32'(mask[8:0]));
      check(rd & 32'hFF00_0001, {31'h0, mask[0]});
    end
    drain(mask, 1'b0, 16'h0800, 16);
    $display("test half threshold done");

    // Stop rollover with a full preset: every counter lands on all-ones.
    wr_reg(RSC_OFS_CTRL, 32'h0000_0032);
    pulse(24'hFFFFFF, 15, 16'h07FF);
    rd_reg(RSC_OFS_IRQ_STAT);
    check(rd, 32'h00FF_FFFF);
    drain(24'hFFFFFF, 1'b1, 16'h07FF, 15);
    pulse(24'hFFFFFF, 1, 16'h0100);
    rd_reg(RSC_OFS_IRQ_STAT);
    check(rd, 32'h0000_0000);
    rd_reg(RSC_OFS_CNT_BASE);
    check(rd, 32'hFFFF_FFFF);
    rd_reg(RSC_OFS_CNT_BASE + 12'h004);
    check(rd, 32'hFFFF_FFFF);
    wr_reg(RSC_OFS_CTRL, 32'h0000_0004);
    rd_reg(RSC_OFS_CNT_BASE + 12'h00C);
    check(rd, 32'hFFFF_FFFF);
    rd_reg(RSC_OFS_CNT_BASE + 12'h00C);
    check(rd, 32'h0000_0000);
    $display("test stop rollover done");

    // The crossing event lands on the very edge that takes the read.
    wr_reg(RSC_OFS_CTRL, 32'h0000_0010);
    pulse(24'h000001, 15, 16'h0000);
    fork
      rd_reg(RSC_OFS_CNT_BASE);
      begin
        repeat (2) @(posedge clk);
        evt <= 24'h000001;
        @(posedge clk);
        evt <= 24'h000000;
      end
    join
    check(rd, 32'h7FFF_FFFF);
    rd_reg(RSC_OFS_IRQ_STAT);
    check(rd, 32'h0000_0001);
    $display("test set over clear done");
    report_and_stop();
  end
endmodule
